// ===== logic/csb_ctrl.sv
// csb_ctrl: processor and bus sideband control, pci interrupt polling,
// irq line routing and a small register file with an interrupt output.
// assumes mclk at 200 MHz; pins are asynchronous, request inputs are on mclk.
// Operation
// - request pci bus for any bus master
// - own bus only while acknowledge asserted
// - four mode: pins are direct inputs
// - eight mode: pin a is mux level
// - eight mode: pins b-d drive selects
// - init polarity follows processor family
// - init on power, kbc, port92, shutdown
// - cold reset until 4 ms after good
// - maskable interrupt from controller pending
// - nmi on check, system or internal error
// - fp error becomes coproc_irq_line when enabled
// - disabled coprocessor: pin is plain coproc_irq_line
// - drive ignore-numeric-error output
// - drive active-low a20 mask
// - irq lines from isa, pci or steer
// - expansion reset on system reset
// - pci reset is inverse of expansion reset
//
// The register addresses and the plain strobed port were left to the implementer.
`timescale 1ns/1ps
module csb_ctrl #(
  parameter int COLD_CYC = csb_pkg::COLD_RST_CYC // shorten for simulation
) (
  input  wire logic        mclk,                   // 200 MHz clock
  input  wire logic        nrst,                   // synchronous reset, low
  input  wire logic [7:0]  reg_addr,               // register byte address
  input  wire logic [31:0] reg_wdata,              // write data
  input  wire logic        reg_wr,                 // write strobe
  input  wire logic        reg_rd,                 // read strobe
  output logic      [31:0] reg_rdata,              // read data, cycle after
  output logic             irq,                    // enabled status pending
  input  wire logic        power_good_in,          // supply good pin
  input  wire logic        isa_master_req,         // bus masters wanting pci
  input  wire logic        dma_req,
  input  wire logic        ide_master_req,
  input  wire logic        usb_master_req,
  input  wire logic        bus_own_ack_n,          // arbiter grant pin
  output logic             bus_own_req_n,          // request to arbiter
  output logic             bus_owner,              // may start master cycles
  input  wire logic        pci_int_a_or_poll_in,   // int a or mux level
  input  wire logic        pci_int_b_or_poll_sel0_i,
  output logic             pci_int_b_or_poll_sel0_o,
  output logic             pci_int_b_or_poll_sel0_oe,
  input  wire logic        pci_int_c_or_poll_sel1_i,
  output logic             pci_int_c_or_poll_sel1_o,
  output logic             pci_int_c_or_poll_sel1_oe,
  input  wire logic        pci_int_d_or_poll_sel2_i,
  output logic             pci_int_d_or_poll_sel2_o,
  output logic             pci_int_d_or_poll_sel2_oe,
  output logic      [7:0]  pci_int_state,          // active-high pci int states
  input  wire logic        kbc_reset_cmd,          // one-cycle pulses on mclk
  input  wire logic        shutdown_cycle,
  output logic             proc_init,              // polarity per family
  output logic             proc_cold_reset,        // high while in reset
  output logic             ignore_numeric_err_n,
  output logic             addr20_mask_n,
  input  wire logic        pic_pending,            // interrupt controller out
  output logic             proc_intr,              // maskable request
  input  wire logic        channel_check_n,        // pins
  input  wire logic        system_error_n,
  input  wire logic        internal_err,           // mclk pulse
  output logic             proc_nmi,
  input  wire logic        fp_error_n,             // pin, also plain coproc_irq_line
  output logic             coproc_irq_line,        // coproc_irq_line to controller
  input  wire logic [15:0] isa_irq_in,             // direct expansion lines
  input  wire logic [15:0] pci_routed_irq,         // from pci routing
  input  wire logic [15:0] steer_irq_in,           // steerable pins
  output logic      [15:0] exp_irq_out,            // selected irq lines
  output logic             exp_bus_reset,
  output logic             pci_bus_reset_n
);

  // two-flop synchronisers for the eight sampled pins; stage one is read only by stage two
  localparam int NSYNC = 8;
  logic [NSYNC-1:0] pin_raw;   // raw pins
  logic [NSYNC-1:0] sync1_q;   // first stage
  logic [NSYNC-1:0] sync2_q;   // safe stage
  assign pin_raw = {fp_error_n, system_error_n, channel_check_n, pci_int_d_or_poll_sel2_i,
                    pci_int_c_or_poll_sel1_i, pci_int_b_or_poll_sel0_i,
                    pci_int_a_or_poll_in, bus_own_ack_n};

  // synchroniser chain, reset to idle-high pin levels except power good
  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      sync1_q <= {NSYNC{1'b1}};
      sync2_q <= {NSYNC{1'b1}};
    end
    else
    begin
      sync1_q <= pin_raw;
      sync2_q <= sync1_q;
    end
  end

  logic pg_s1_q;   // power good first stage
  logic pg_s2_q;   // power good safe stage
  // power good sync kept apart: it must reset low so reset holds
  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      pg_s1_q <= 1'b0;
      pg_s2_q <= 1'b0;
    end
    else
    begin
      pg_s1_q <= power_good_in;
      pg_s2_q <= pg_s1_q;
    end
  end

  logic ack_s, inta_s, intb_s, intc_s, intd_s, chk_s, serr_s, ferr_s;
  assign {ferr_s, serr_s, chk_s, intd_s, intc_s, intb_s, inta_s, ack_s} = sync2_q;

  // control registers; status width must be known before the fields below
  localparam int ST_W = csb_pkg::ST_W;
  logic [7:0]      ctrl_q;   // mode and control bits
  logic [ST_W-1:0] stat_q;   // sticky status
  logic [ST_W-1:0] ien_q;    // interrupt enable
  logic [31:0]     route_q;  // two bits per irq line
  logic wr_ctrl, wr_evq, wr_ien, wr_iclr, wr_route;
  assign wr_ctrl  = reg_wr && reg_addr == csb_pkg::CTRL_OFS;
  assign wr_evq   = reg_wr && reg_addr == csb_pkg::EVREQ_OFS;
  assign wr_ien   = reg_wr && reg_addr == csb_pkg::IEN_OFS;
  assign wr_iclr  = reg_wr && reg_addr == csb_pkg::ICLR_OFS;
  assign wr_route = reg_wr && reg_addr == csb_pkg::ROUTE_OFS;

  // writable configuration
  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      ctrl_q  <= csb_pkg::CTRL_RST;
      ien_q   <= '0;
      route_q <= '0;
    end
    else
    begin
      if (wr_ctrl)
        ctrl_q <= reg_wdata[7:0];
      if (wr_ien)
        ien_q <= reg_wdata[ST_W-1:0];
      if (wr_route)
        route_q <= reg_wdata;
    end
  end

  // cold reset sequencer: held while power good is low, then timed release
  csb_pkg::csb_cr_t cr_q;      // state
  logic [31:0]      cr_cnt_q;  // cycles since power good
  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      cr_q     <= csb_pkg::CR_HOLD;
      cr_cnt_q <= '0;
    end
    else if (!pg_s2_q)
    begin
      // supply dropped: restart the whole sequence
      cr_q     <= csb_pkg::CR_HOLD;
      cr_cnt_q <= '0;
    end
    else
    begin
      case (cr_q)
        csb_pkg::CR_HOLD:
          cr_q <= csb_pkg::CR_COUNT;
        csb_pkg::CR_COUNT:
        begin
          // release once the full delay has been counted
          if (cr_cnt_q >= 32'(COLD_CYC - 1))
            cr_q <= csb_pkg::CR_RUN;
          cr_cnt_q <= cr_cnt_q + 32'h1;
        end
        csb_pkg::CR_RUN:
          cr_q <= csb_pkg::CR_RUN;
        default:
          cr_q <= csb_pkg::CR_HOLD;
      endcase
    end
  end

  logic cold_d;  // cold reset level
  logic sysrst_d; // system reset level
  assign cold_d   = cr_q != csb_pkg::CR_RUN;
  assign sysrst_d = cold_d || ctrl_q[csb_pkg::CTRL_SYSRST];

  // reset outputs; expansion and pci resets come from one level so they never skew
  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      proc_cold_reset <= 1'b1;
      exp_bus_reset   <= 1'b1;
      pci_bus_reset_n <= 1'b0;
    end
    else
    begin
      proc_cold_reset <= cold_d;
      exp_bus_reset   <= sysrst_d;
      pci_bus_reset_n <= !sysrst_d;
    end
  end

  // init: stretched pulse from any trigger; power-on keeps it active
  logic        init_trig;   // any init cause this cycle
  logic [7:0]  init_cnt_q;  // remaining pulse cycles
  logic        init_act;    // init active level
  assign init_trig = cold_d || kbc_reset_cmd || shutdown_cycle
                   || (wr_evq && (reg_wdata[csb_pkg::EVQ_KBC] || reg_wdata[csb_pkg::EVQ_P92]));
  assign init_act  = init_trig || init_cnt_q != 8'h00;
  always_ff @(posedge mclk)
  begin
    if (!nrst)
      init_cnt_q <= 8'h00;
    else if (init_trig)
      init_cnt_q <= 8'(csb_pkg::INIT_CYC - 1);
    else if (init_cnt_q != 8'h00)
      init_cnt_q <= init_cnt_q - 8'h01;
  end

  // processor control outputs
  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      proc_init            <= 1'b1; // high-active family is the default
      ignore_numeric_err_n <= 1'b1;
      addr20_mask_n        <= 1'b1;
      proc_intr            <= 1'b0;
    end
    else
    begin
      // later family wants low-active init
      proc_init            <= init_act ^ ctrl_q[csb_pkg::CTRL_FAMILY];
      ignore_numeric_err_n <= !ctrl_q[csb_pkg::CTRL_IGNNE];
      addr20_mask_n        <= !ctrl_q[csb_pkg::CTRL_A20M];
      proc_intr            <= pic_pending;
    end
  end

  // pci bus request and ownership
  logic any_req;
  assign any_req = isa_master_req || dma_req || ide_master_req || usb_master_req;
  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      bus_own_req_n <= 1'b1;
      bus_owner     <= 1'b0;
    end
    else
    begin
      bus_own_req_n <= !any_req;
      bus_owner     <= !ack_s && any_req;
    end
  end

  // polling: select steps through eight inputs, sampling after settle time
  logic       poll8;       // eight-interrupt mode
  logic [2:0] psel_q;      // mux select
  logic [7:0] pwait_q;     // settle counter
  logic [7:0] pstate_q;    // polled states
  assign poll8 = ctrl_q[csb_pkg::CTRL_POLL8];
  always_ff @(posedge mclk)
  begin
    if (!nrst || !poll8)
    begin
      psel_q   <= 3'h0;
      pwait_q  <= 8'h00;
      pstate_q <= 8'h00;
    end
    else if (pwait_q >= 8'(csb_pkg::POLL_CYC + 1))
    begin
      // two extra cycles cover the synchroniser delay on the level
      pstate_q[psel_q] <= !inta_s;
      psel_q           <= psel_q + 3'h1;
      pwait_q          <= 8'h00;
    end
    else
      pwait_q <= pwait_q + 8'h01;
  end

  // select pins and the published interrupt states
  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      {pci_int_d_or_poll_sel2_o, pci_int_c_or_poll_sel1_o,
       pci_int_b_or_poll_sel0_o} <= 3'h0;
      pci_int_b_or_poll_sel0_oe <= 1'b0;
      pci_int_c_or_poll_sel1_oe <= 1'b0;
      pci_int_d_or_poll_sel2_oe <= 1'b0;
      pci_int_state             <= 8'h00;
    end
    else
    begin
      {pci_int_d_or_poll_sel2_o, pci_int_c_or_poll_sel1_o,
       pci_int_b_or_poll_sel0_o} <= psel_q;
      pci_int_b_or_poll_sel0_oe <= poll8;
      pci_int_c_or_poll_sel1_oe <= poll8;
      pci_int_d_or_poll_sel2_oe <= poll8;
      if (poll8)
        pci_int_state <= pstate_q;
      else
        pci_int_state <= {4'h0, !intd_s, !intc_s, !intb_s, !inta_s};
    end
  end

  // coproc_irq_line: converted error when enabled, plain request pin when disabled
  logic coproc_irq_line_d;
  assign coproc_irq_line_d = ctrl_q[csb_pkg::CTRL_CPDIS] ? ferr_s : !ferr_s;

  // expansion irq line source select, one instance per line
  logic [15:0] exp_irq_d;
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++)
    begin : g_route
      always_comb
      begin
        case (route_q[2*gi +: 2])
          csb_pkg::SRC_PCI:   exp_irq_d[gi] = pci_routed_irq[gi];
          csb_pkg::SRC_STEER: exp_irq_d[gi] = steer_irq_in[gi];
          default:            exp_irq_d[gi] = isa_irq_in[gi];
        endcase
      end
    end
  endgenerate

  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      exp_irq_out     <= 16'h0000;
      coproc_irq_line <= 1'b0;
    end
    else
    begin
      exp_irq_out     <= exp_irq_d;
      coproc_irq_line <= coproc_irq_line_d;
    end
  end

  // sticky status: a set in the same cycle as its clear wins
  logic [ST_W-1:0] ev_set;
  logic            init_trig_d_q; // edge finder for init events
  assign ev_set = {init_trig && !init_trig_d_q, !ferr_s && !ctrl_q[csb_pkg::CTRL_CPDIS],
                   internal_err, !serr_s, !chk_s};
  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      stat_q        <= '0;
      init_trig_d_q <= 1'b0;
    end
    else
    begin
      init_trig_d_q <= init_trig;
      stat_q        <= (stat_q & ~(wr_iclr ? reg_wdata[ST_W-1:0] : '0)) | ev_set;
    end
  end

  // nmi from error events, interrupt from enabled status
  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      proc_nmi <= 1'b0;
      irq      <= 1'b0;
    end
    else
    begin
      proc_nmi <= |stat_q[csb_pkg::ST_IERR:csb_pkg::ST_CHK];
      irq      <= |(stat_q & ien_q);
    end
  end

  // read port: data stand only in the cycle after the strobe
  always_ff @(posedge mclk)
  begin
    if (!nrst || !reg_rd)
      reg_rdata <= 32'h0000_0000;
    else
    begin
      case (reg_addr)
        csb_pkg::CTRL_OFS:  reg_rdata <= {24'h0, ctrl_q};
        csb_pkg::STAT_OFS:  reg_rdata <= {{(32-ST_W){1'b0}}, stat_q};
        csb_pkg::IEN_OFS:   reg_rdata <= {{(32-ST_W){1'b0}}, ien_q};
        csb_pkg::PIRQ_OFS:  reg_rdata <= {24'h0, pci_int_state};
        csb_pkg::ROUTE_OFS: reg_rdata <= route_q;
        default:            reg_rdata <= 32'h0000_0000; // unmapped reads zero
      endcase
    end
  end

  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  a_pci_rst_inv:   assert property (pci_bus_reset_n == !exp_bus_reset)
    else $error("pci reset not inverse of expansion reset");
  a_cold_until_pg: assert property (!pg_s2_q |=> ##1 proc_cold_reset)
    else $error("cold reset released without power good");
  a_owner_ack:     assert property (bus_owner |-> $past(!ack_s))
    else $error("bus owned without acknowledge");
  a_req_follows:   assert property (any_req |=> !bus_own_req_n)
    else $error("bus request not raised");
  a_poll_oe:       assert property (poll8 |=> pci_int_b_or_poll_sel0_oe)
    else $error("select pins not driven in polling mode");
  a_init_kbc:      assert property (kbc_reset_cmd |=> proc_init != ctrl_q[csb_pkg::CTRL_FAMILY])
    else $error("init not active after kbc reset");
  a_nmi_serr:      assert property (!serr_s |=> ##1 proc_nmi)
    else $error("nmi missing after system error");
  a_stat_sticky:   assert property (stat_q[0] && !wr_iclr |=> stat_q[0])
    else $error("status bit lost without clear");
  a_four_direct:   assert property (!poll8 && !$past(poll8) |=> pci_int_state[7:4] == 4'h0)
    else $error("upper pci states set in four mode");

  c_cold_release:  cover property ($fell(proc_cold_reset));
  c_poll_wrap:     cover property (poll8 && psel_q == 3'h7 ##[1:20] psel_q == 3'h0);
  c_owner:         cover property ($rose(bus_owner));
endmodule

// ===== logic/csb_pkg.sv
// csb_pkg: constants shared by the sideband control block
// assumes a 200 MHz mclk and a plain strobe register port
package csb_pkg;
  // register offsets (byte addresses on the 8-bit reg_addr of the 32-bit register port)
  localparam logic [7:0] CTRL_OFS   = 8'h00; // mode and processor control bits
  localparam logic [7:0] EVREQ_OFS  = 8'h04; // write-only init request strobes
  localparam logic [7:0] STAT_OFS   = 8'h08; // sticky event status, read-only
  localparam logic [7:0] IEN_OFS    = 8'h0c; // interrupt enable, same layout
  localparam logic [7:0] ICLR_OFS   = 8'h10; // write one to clear status
  localparam logic [7:0] PIRQ_OFS   = 8'h14; // pci interrupt states, read-only
  localparam logic [7:0] ROUTE_OFS  = 8'h18; // 2-bit source select per irq line
  // control register fields
  localparam int CTRL_POLL8   = 0; // 1: eight-interrupt polling mode
  localparam int CTRL_FAMILY  = 1; // 1: later family, init active low
  localparam int CTRL_IGNNE   = 2; // 1: processor ignores numeric errors
  localparam int CTRL_A20M    = 3; // 1: mask address line 20
  localparam int CTRL_SYSRST  = 4; // 1: hold system reset
  localparam int CTRL_CPDIS   = 6; // 1: coprocessor interface disabled
  localparam logic [7:0] CTRL_RST = 8'h00;
  // init request strobe bits
  localparam int EVQ_KBC  = 0; // keyboard controller reset command
  localparam int EVQ_P92  = 1; // port 92 reset request
  // status bits
  localparam int ST_CHK   = 0; // channel check
  localparam int ST_SERR  = 1; // system error
  localparam int ST_IERR  = 2; // internal error
  localparam int ST_FERR  = 3; // floating-point error seen
  localparam int ST_INIT  = 4; // init issued
  localparam int ST_W     = 5;
  // irq line routing sources
  localparam logic [1:0] SRC_ISA   = 2'h0;
  localparam logic [1:0] SRC_PCI   = 2'h1;
  localparam logic [1:0] SRC_STEER = 2'h2;
  // timing
  localparam int  CLK_MHZ         = 200;
  localparam int  COLD_RST_US     = 4000; // 4 ms after power good
  localparam int  COLD_RST_CYC    = COLD_RST_US * CLK_MHZ;
  localparam int  INIT_NS         = 80;   // init pulse width
  localparam int  INIT_CYC        = (INIT_NS * CLK_MHZ + 999) / 1000;
  localparam int  POLL_SETTLE_NS  = 60;   // mux select to sample
  localparam int  POLL_CYC        = (POLL_SETTLE_NS * CLK_MHZ + 999) / 1000;
  // cold reset sequencer
  typedef enum logic [1:0] {
    CR_HOLD  = 2'b00, // power good low
    CR_COUNT = 2'b01, // timing the release
    CR_RUN   = 2'b10  // released
  } csb_cr_t;
endpackage

// ===== bench/csb_far_model.sv
// csb_far_model: host-side bus arbiter and external interrupt mux
// assumes the bench supplies the eight mux sources and four direct lines
`timescale 1ns/1ps
module csb_far_model (
  input  wire logic       mclk,    // shared clock
  input  wire logic       slow,    // 1: grant arrives late
  input  wire logic       req_n,   // ownership request from the block
  output logic            ack_n,   // ownership grant to the block
  input  wire logic [7:0] src_n,   // polled sources, active low
  input  wire logic [3:0] dir_n,   // direct lines a..d, active low
  input  wire logic [2:0] sel_o,   // select drive from the block
  input  wire logic [2:0] sel_oe,  // select enables from the block
  output logic            pin_a,   // int a wire or mux output
  output logic [2:0]      pin_bcd  // resolved b..d wire levels
);
  logic [3:0] wait_q;              // cycles left before the grant

  // grant only after the request has stood a while; drop it at once
  always_ff @(posedge mclk)
  begin
    if (req_n !== 1'b0)
    begin
      wait_q <= slow ? 4'h8 : 4'h1;
      ack_n  <= 1'b1;
    end
    else if (wait_q != 4'h0)
      wait_q <= wait_q - 4'h1;
    else
      ack_n <= 1'b0;
  end

  // a pin the block does not drive carries its direct interrupt level
  assign pin_bcd = (sel_oe & sel_o) | (~sel_oe & dir_n[3:1]);
  // the mux answers only while all three selects are driven
  assign pin_a = (&sel_oe) ? src_n[pin_bcd] : dir_n[0];
endmodule

// ===== bench/csb_ctrl_tb_top.sv
// csb_ctrl_tb_top: self-checking bench for the sideband control block
// assumes csb_far_model stands in for the arbiter and the interrupt mux
`timescale 1ns/1ps
module csb_ctrl_tb_top;
  localparam int COLD = 20;                 // short cold reset count
  logic        mclk = 1'b0;                 // 200 MHz clock
  logic        nrst, reg_wr, reg_rd, irq;   // reset and register strobes
  logic [7:0]  reg_addr, src_n, pci_int_state;
  logic [31:0] reg_wdata, reg_rdata, v, r;
  logic        power_good_in, slow, ack_n, bus_own_req_n, bus_owner;
  logic [3:0]  mreq, dir_n;                 // isa, dma, ide, usb requests
  logic [2:0]  pin_bcd, sel_o, sel_oe, errs; // errs: check, serr, internal
  logic [1:0]  trig;                        // kbc reset, shutdown pulses
  logic        pin_a, proc_init, proc_cold_reset, ignore_numeric_err_n;
  logic        addr20_mask_n, pic_pending, proc_intr, proc_nmi, fp_n;
  logic        coproc_irq_line, exp_bus_reset, pci_bus_reset_n;
  logic [15:0] exp_irq_out;
  int          fail_count, checked, i, n;
  // rows: ctrl, route, pic, {intr, ignne_n, a20_n, exp rst, pci rst_n}, irq lines
  logic [31:0] rows [4] = '{32'h000d00ff, 32'h04750f0f, 32'h08893333, 32'h10fe00ff};

  always #2.5 mclk = ~mclk;

  csb_ctrl #(.COLD_CYC(COLD)) dut (
    .mclk(mclk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
    .power_good_in(power_good_in), .isa_master_req(mreq[0]), .dma_req(mreq[1]),
    .ide_master_req(mreq[2]), .usb_master_req(mreq[3]), .bus_own_ack_n(ack_n),
    .bus_own_req_n(bus_own_req_n), .bus_owner(bus_owner), .pci_int_a_or_poll_in(pin_a),
    .pci_int_b_or_poll_sel0_i(pin_bcd[0]), .pci_int_b_or_poll_sel0_o(sel_o[0]),
    .pci_int_b_or_poll_sel0_oe(sel_oe[0]), .pci_int_c_or_poll_sel1_i(pin_bcd[1]),
    .pci_int_c_or_poll_sel1_o(sel_o[1]), .pci_int_c_or_poll_sel1_oe(sel_oe[1]),
    .pci_int_d_or_poll_sel2_i(pin_bcd[2]), .pci_int_d_or_poll_sel2_o(sel_o[2]),
    .pci_int_d_or_poll_sel2_oe(sel_oe[2]), .pci_int_state(pci_int_state),
    .kbc_reset_cmd(trig[0]), .shutdown_cycle(trig[1]), .proc_init(proc_init),
    .proc_cold_reset(proc_cold_reset), .ignore_numeric_err_n(ignore_numeric_err_n),
    .addr20_mask_n(addr20_mask_n), .pic_pending(pic_pending), .proc_intr(proc_intr),
    .channel_check_n(~errs[0]), .system_error_n(~errs[1]), .internal_err(errs[2]),
    .proc_nmi(proc_nmi), .fp_error_n(fp_n), .coproc_irq_line(coproc_irq_line),
    .isa_irq_in(16'h00ff), .pci_routed_irq(16'h0f0f), .steer_irq_in(16'h3333),
    .exp_irq_out(exp_irq_out), .exp_bus_reset(exp_bus_reset),
    .pci_bus_reset_n(pci_bus_reset_n)
  );

  csb_far_model far (
    .mclk(mclk), .slow(slow), .req_n(bus_own_req_n), .ack_n(ack_n), .src_n(src_n),
    .dir_n(dir_n), .sel_o(sel_o), .sel_oe(sel_oe), .pin_a(pin_a), .pin_bcd(pin_bcd)
  );

  // compare and count; unknowns never match
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // one-cycle register write
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  // one-cycle read; data stands only in the following cycle
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  // verdict and end of run
  task automatic results;
    if (fail_count == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // watchdog sized well beyond the fewer than one thousand cycles the tests take
  initial
  begin
    #60us;
    fail_count++;
    results();
  end

  initial
  begin
    {nrst, reg_wr, reg_rd, power_good_in, slow, pic_pending, fp_n} = 7'b0000001;
    {reg_addr, reg_wdata, mreq, errs, trig} = '0;
    src_n = 8'hff;
    dir_n = 4'hf;
    fail_count = 0;
    checked = 0;
    // reset values, then cold reset waits for power good plus the count
    repeat (7) @(posedge mclk);
    #1 chk({proc_cold_reset, exp_bus_reset, pci_bus_reset_n}, 3'b110);
    chk(proc_init, 1'b1);
    @(posedge mclk);
    nrst <= 1'b1;
    repeat (30) @(posedge mclk);
    #1 chk(proc_cold_reset, 1'b1);
    @(posedge mclk);
    power_good_in <= 1'b1;
    repeat (COLD) @(posedge mclk);
    #1 chk(proc_cold_reset, 1'b1);
    for (n = 0; n < 10 && proc_cold_reset !== 1'b0; n++) @(posedge mclk);
    #1 chk(proc_cold_reset, 1'b0);
    repeat (30) @(posedge mclk);
    // clear power-on status, then a refused write and an unmapped read
    wr(csb_pkg::ICLR_OFS, 32'h1f);
    wr(csb_pkg::STAT_OFS, 32'hff);
    rd(csb_pkg::STAT_OFS, v);
    chk(v, 32'h0);
    rd(8'h1c, v);
    chk(v, 32'h0);
    // table of control, routing and maskable request cases
    for (i = 0; i < 4; i++)
    begin
      r = rows[i];
      wr(csb_pkg::CTRL_OFS, {24'h0, r[31:24]});
      pic_pending <= r[21];
      wr(csb_pkg::ROUTE_OFS, {16{r[23:22]}});
      repeat (3) @(posedge mclk);
      #1 chk({proc_intr, ignore_numeric_err_n, addr20_mask_n, exp_bus_reset,
              pci_bus_reset_n, exp_irq_out}, r[20:0]);
    end
    wr(csb_pkg::CTRL_OFS, 32'h0);
    // each master alone, prompt and slow grant
    for (i = 0; i < 8; i++)
    begin
      @(posedge mclk);
      slow <= i[2];
      mreq <= 4'h1 << i[1:0];
      repeat (3) @(posedge mclk);
      #1 chk({bus_own_req_n, bus_owner}, 2'b00);
      for (n = 0; n < 30 && bus_owner !== 1'b1; n++) @(posedge mclk);
      #1 chk(bus_owner, 1'b1);
      @(posedge mclk);
      mreq <= 4'h0;
      repeat (4) @(posedge mclk);
      #1 chk({bus_own_req_n, bus_owner}, 2'b10);
    end
    // each error source: masked first, then enabled, then cleared
    for (i = 0; i < 3; i++)
    begin
      wr(csb_pkg::IEN_OFS, 32'h0);
      errs <= 3'b001 << i;
      @(posedge mclk);
      errs <= 3'b000;
      repeat (5) @(posedge mclk);
      #1 chk({proc_nmi, irq}, 2'b10);
      rd(csb_pkg::STAT_OFS, v);
      chk(v[2:0], 3'b001 << i);
      wr(csb_pkg::IEN_OFS, 32'h1 << i);
      repeat (2) @(posedge mclk);
      #1 chk(irq, 1'b1);
      wr(csb_pkg::ICLR_OFS, 32'h1 << i);
      repeat (3) @(posedge mclk);
      #1 chk({proc_nmi, irq}, 2'b00);
    end
    // init triggers, alternating processor family
    for (i = 0; i < 4; i++)
    begin
      wr(csb_pkg::CTRL_OFS, {30'h0, i[0], 1'b0});
      repeat (20) @(posedge mclk);
      #1 chk(proc_init, i[0]);
      if (i < 2)
      begin
        @(posedge mclk);
        trig <= 2'b01 << i;
        @(posedge mclk);
        trig <= 2'b00;
      end
      else
        wr(csb_pkg::EVREQ_OFS, 32'(i - 1));
      repeat (3) @(posedge mclk);
      #1 chk(proc_init, !i[0]);
      repeat (20) @(posedge mclk);
      #1 chk(proc_init, i[0]);
    end
    // floating-point error with the coprocessor on and off
    for (i = 0; i < 4; i++)
    begin
      wr(csb_pkg::CTRL_OFS, {25'h0, i[1], 6'h0});
      fp_n <= i[0];
      repeat (5) @(posedge mclk);
      #1 chk(coproc_irq_line, i[1] ? i[0] : !i[0]);
    end
    // four direct lines, then eight polled sources
    wr(csb_pkg::CTRL_OFS, 32'h0);
    dir_n <= 4'b1010;
    repeat (5) @(posedge mclk);
    #1 chk({sel_oe, pci_int_state[3:0]}, 7'h05);
    src_n <= 8'h5a;
    wr(csb_pkg::CTRL_OFS, 32'h1);
    repeat (3) @(posedge mclk);
    #1 chk(sel_oe, 3'b111);
    repeat (250) @(posedge mclk);
    #1 chk(pci_int_state, 8'ha5);
    rd(csb_pkg::PIRQ_OFS, v);
    chk(v, 32'ha5);
    results();
  end
endmodule
